// ---- hw/sanitize_consts.svh ----
// Constants for the sanitize and security-in command block
`ifndef SANITIZE_CONSTS_SVH
`define SANITIZE_CONSTS_SVH

// ****************************************************************
// Opcodes, service actions and protocol codes
// ****************************************************************
`define OPC_SANITIZE 8'h48
`define OPC_SEC_IN 8'ha2
`define SA_OVERWRITE 5'h01
`define SA_CRYPTO 5'h03
`define SA_EXIT_FAIL 5'h1f
`define PROT_INFO 8'h00
`define PROT_EXT_LAST 8'h06

// ****************************************************************
// Field positions
// ****************************************************************
`define IMMED_BIT 7
`define UXF_BIT 5
`define SA_MSB 4
`define SA_LSB 0
`define INC512_BIT 7
`define PINV_BIT 7
`define OVW_CNT_MSB 4
`define UNIT512_SHIFT 9
`define PARM_HDR_LAST 11'h003
`define PARM_LEN_HI 11'h002

// ****************************************************************
// Values
// ****************************************************************
`define OVW_CNT_RSVD 5'h00
`define PAT_MAX 16'h0200
`define PAD_VALUE 8'h00
`define PI_FILL 8'hff
`define SK_NOT_READY 4'h2
`define SK_MEDIUM 4'h3
`define SK_ILLEGAL 4'h5
`define ASC_NOT_READY 8'h04
`define ASC_BAD_CDB 8'h24
`define ASC_BAD_PARM 8'h26
`define ASC_SAN_FAIL 8'h31
`define ASCQ_NONE 8'h00

`endif

// ---- hw/sanitize_pkg.sv ----
// Types shared by the sanitize and security-in command block
package sanitize_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PARM = 3'b001,
    ST_FILL = 3'b011,
    ST_CRYPT = 3'b100,
    ST_DONE = 3'b010
  } san_state_e;

  typedef logic [40:0] byte_count_t;

  typedef struct packed {
    logic [95:0] bytes;
    logic [5:0] it_id;
    logic [1:0] lun;
  } cdb_s;

  typedef struct packed {
    logic valid;
    logic check;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } status_s;

  typedef struct packed {
    logic valid;
    logic info;
    logic has_data;
    logic empty;
    byte_count_t xfer_len;
    byte_count_t pad_len;
    logic [7:0] pad_byte;
  } spin_s;

endpackage

// ---- hw/pattern_gen.sv ----
// Overwrite byte generator: repeats the pattern per block, PI as fill
`timescale 1ns/1ps
`include "sanitize_consts.svh"

module pattern_gen (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ld,
  input wire logic [8:0] i_ld_idx,
  input wire logic [7:0] i_ld_byte,
  input wire logic i_start,
  input wire logic i_adv,
  input wire logic [9:0] i_pat_len,
  input wire logic [15:0] i_blk_len,
  input wire logic [3:0] i_pi_len,
  input wire logic i_inv,
  output logic [7:0] o_byte,
  output logic o_last
);

  logic [7:0] mem [0:511];
  logic [8:0] pat_idx_r;
  logic [15:0] pos_r;
  wire in_data = pos_r < i_blk_len;
  wire [16:0] blk_end = {1'b0, i_blk_len} + {13'h0000, i_pi_len} - 17'h00001;
  wire pat_wrap = {1'b0, pat_idx_r} == (i_pat_len - 10'h001);
  wire [7:0] raw_byte = in_data ? mem[pat_idx_r] : `PI_FILL; // [RQ13]

  assign o_last = {1'b0, pos_r} == blk_end;
  assign o_byte = raw_byte ^ {8{i_inv}}; // [RQ9]

  // Pattern store has no reset; it is always loaded before use
  always_ff @(posedge i_clk_sys) begin
    if (i_ld) begin
      mem[i_ld_idx] <= i_ld_byte;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pat_idx_r <= 9'h000;
      pos_r <= 16'h0000;
    end else if (i_start) begin
      pat_idx_r <= 9'h000;
      pos_r <= 16'h0000;
    end else if (i_adv) begin
      if (o_last) begin
        // Each block restarts at the first pattern byte
        pat_idx_r <= 9'h000; // [RQ12]
        pos_r <= 16'h0000;
      end else begin
        pos_r <= pos_r + 16'h0001;
        if (in_data) begin
          pat_idx_r <= pat_wrap ? 9'h000 : pat_idx_r + 9'h001; // [RQ12]
        end
      end
    end
  end

endmodule

// ---- hw/sanitize_sec_in.sv ----
// Sanitize and security-in command decoding, sequencing and results
`timescale 1ns/1ps
`include "sanitize_consts.svh"

// How it works
// RQ1 - Immediate flag clear: completion status only after the sanitize ends.
// RQ2 - Immediate flag set: good status at acceptance; busy shows progress.
// RQ3 - Exit request accepted only if failed sanitize had unrestricted exit.
// RQ4 - Nonzero parameter list length gives check condition, bad CDB field.
// RQ5 - Reserved service actions give check condition, bad CDB field.
// RQ6 - Service action 01h runs the multi-pass overwrite.
// RQ7 - Service action 03h requests an encryption key change.
// RQ8 - Service action 1Fh clears the sanitize-failed state when allowed.
// RQ9 - Invert flag set flips every bit on alternate overwrite passes.
// RQ10 - Overwrite count sets pass number; zero count is refused.
// RQ11 - Pattern length zero or over block length gives parameter error.
// RQ12 - Pattern repeats through each block, restarting at every block.
// RQ13 - Protection information bytes are written as all ones; on inverted passes the code writes them as 00h.
// RQ14 - Opcode A2h: code 00h info, 01h-06h protocols, rest reserved.
// RQ15 - Unit bit set: allocation in 512-byte units, pads are 00h.
// RQ16 - Unit bit clear: allocation length counts single bytes.
// RQ17 - No retained results: answer reports nothing to transfer.
// RQ18 - Results kept until read by same nexus, reset, or nexus loss.
// RQ19 - Byte 1 holds immediate bit 7, exit flag bit 5, action 4..0.

module sanitize_sec_in (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input sanitize_pkg::cdb_s i_cmd,
  input wire logic i_parm_valid,
  input wire logic [7:0] i_parm_byte,
  output logic o_parm_ready,
  input wire logic [15:0] i_blk_len,
  input wire logic [3:0] i_pi_len,
  input wire logic [31:0] i_num_blocks,
  output logic o_wr_valid,
  output logic [7:0] o_wr_byte,
  input wire logic i_wr_ready,
  output logic o_key_change,
  input wire logic i_key_done,
  input wire logic i_media_fail,
  output sanitize_pkg::status_s o_cmd_status,
  output sanitize_pkg::status_s o_done_status,
  output sanitize_pkg::spin_s o_spin,
  output logic o_busy,
  output logic o_failed,
  input wire logic i_res_store,
  input wire logic [5:0] i_res_it,
  input wire logic [1:0] i_res_lun,
  input wire logic [31:0] i_res_len,
  input wire logic i_it_loss,
  input wire logic [5:0] i_loss_it
);
  import sanitize_pkg::*;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire [7:0] opc = i_cmd.bytes[95:88];
  wire [7:0] byte1 = i_cmd.bytes[87:80];
  wire [7:0] byte4 = i_cmd.bytes[63:56];
  wire [15:0] san_plen = i_cmd.bytes[39:24];
  wire [31:0] alloc_len = i_cmd.bytes[47:16];
  wire is_san = i_cmd_valid && (opc == `OPC_SANITIZE);
  wire is_spin = i_cmd_valid && (opc == `OPC_SEC_IN); // [RQ14]
  wire c_immed = byte1[`IMMED_BIT]; // [RQ19]
  wire c_uxf = byte1[`UXF_BIT]; // [RQ19]
  wire [4:0] c_sa = byte1[`SA_MSB:`SA_LSB]; // [RQ19]
  wire sa_ovw = c_sa == `SA_OVERWRITE; // [RQ6]
  wire sa_cry = c_sa == `SA_CRYPTO; // [RQ7]
  wire sa_exit = c_sa == `SA_EXIT_FAIL;
  wire sa_rsvd = !(sa_ovw || sa_cry || sa_exit); // [RQ5]
  wire plen_bad = san_plen != 16'h0000; // [RQ4]
  wire inc512 = byte4[`INC512_BIT];
  wire prot_rsvd = byte1 > `PROT_EXT_LAST; // [RQ14]
  wire prot_info = byte1 == `PROT_INFO;
  // Both forms widened to one count so the data path never scales
  wire [40:0] xfer_len = inc512 ? {alloc_len, 9'h000} : // [RQ15]
                                  {9'h000, alloc_len}; // [RQ16]

  // ****************************************************************
  // State
  // ****************************************************************
  san_state_e state_r, state_nxt;
  logic immed_r, uxf_r, failed_r, failed_uxf_r, inv_r, all_done_r;
  logic [4:0] ovw_cnt_r, pass_r;
  logic [31:0] blk_r;
  logic [10:0] parm_idx_r;
  logic [7:0] len_hi_r;
  logic [9:0] pat_len_r;
  logic res_valid_r;
  logic [5:0] res_it_r;
  logic [1:0] res_lun_r;
  logic [31:0] res_len_r;
  logic [7:0] gen_byte;
  logic gen_last;
  status_s cmd_st_nxt, done_st_nxt;
  spin_s spin_nxt;

  wire parm_take = (state_r == ST_PARM) && i_parm_valid && o_parm_ready;
  wire hdr_done = parm_take && (parm_idx_r == `PARM_HDR_LAST);
  wire [15:0] pat_len_in = {len_hi_r, i_parm_byte};
  wire parm_bad = (pat_len_in == 16'h0000) || // [RQ11]
                  (pat_len_in > i_blk_len) || // [RQ11]
                  (pat_len_in > `PAT_MAX) ||
                  (ovw_cnt_r == `OVW_CNT_RSVD); // [RQ10]
  wire [10:0] pat_pos = parm_idx_r - 11'h004;
  wire pat_load = parm_take && (parm_idx_r > `PARM_HDR_LAST);
  wire pat_end = pat_load && (pat_pos == {1'b0, pat_len_r} - 11'h001);
  wire fill_take = (state_r == ST_FILL) && !all_done_r &&
                   (!o_wr_valid || i_wr_ready);
  wire last_blk = blk_r == i_num_blocks - 32'h00000001;
  wire last_pass = pass_r == ovw_cnt_r - 5'h01; // [RQ10]
  wire fill_end = all_done_r && !o_wr_valid;
  wire pass_inv = inv_r && pass_r[0]; // [RQ9]
  wire run_fail = i_media_fail &&
                  ((state_r == ST_FILL) || (state_r == ST_CRYPT));
  wire san_start = is_san && !plen_bad && !sa_rsvd && !sa_exit &&
                   (state_r == ST_IDLE);
  wire exit_ok = failed_r && failed_uxf_r; // [RQ3]
  wire res_hit = res_valid_r && (res_it_r == i_cmd.it_id) &&
                 (res_lun_r == i_cmd.lun);
  wire res_read = is_spin && !prot_rsvd && !prot_info && res_hit;
  wire res_lost = i_it_loss && (i_loss_it == res_it_r);

  pattern_gen u_gen (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ld(pat_load),
    .i_ld_idx(pat_pos[8:0]),
    .i_ld_byte(i_parm_byte),
    .i_start(hdr_done),
    .i_adv(fill_take),
    .i_pat_len(pat_len_r),
    .i_blk_len(i_blk_len),
    .i_pi_len(i_pi_len),
    .i_inv(pass_inv),
    .o_byte(gen_byte),
    .o_last(gen_last)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (san_start && sa_ovw) begin
          state_nxt = ST_PARM; // [RQ6]
        end else if (san_start && sa_cry) begin
          state_nxt = ST_CRYPT; // [RQ7]
        end
      end
      ST_PARM: begin
        if (hdr_done && parm_bad) begin
          state_nxt = ST_IDLE;
        end else if (pat_end) begin
          state_nxt = ST_FILL;
        end
      end
      ST_FILL: begin
        if (run_fail) begin
          state_nxt = ST_IDLE;
        end else if (fill_end) begin
          state_nxt = ST_DONE;
        end
      end
      ST_CRYPT: begin
        if (run_fail) begin
          state_nxt = ST_IDLE;
        end else if (i_key_done) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Answers
  // ****************************************************************
  always_comb begin
    cmd_st_nxt = '0;
    if (is_san) begin
      cmd_st_nxt.check = 1'b1;
      cmd_st_nxt.sense_key = `SK_ILLEGAL;
      cmd_st_nxt.asc = `ASC_BAD_CDB;
      cmd_st_nxt.ascq = `ASCQ_NONE;
      if (plen_bad || sa_rsvd) begin
        cmd_st_nxt.valid = 1'b1; // [RQ4] [RQ5]
      end else if (sa_exit) begin
        cmd_st_nxt.valid = 1'b1;
        cmd_st_nxt.check = !exit_ok; // [RQ3] [RQ8]
      end else if (state_r != ST_IDLE) begin
        cmd_st_nxt.valid = 1'b1;
        cmd_st_nxt.sense_key = `SK_NOT_READY;
        cmd_st_nxt.asc = `ASC_NOT_READY;
      end else if (c_immed) begin
        cmd_st_nxt.valid = 1'b1; // [RQ2]
        cmd_st_nxt.check = 1'b0;
      end
    end else if (is_spin) begin
      cmd_st_nxt.valid = 1'b1;
      cmd_st_nxt.check = prot_rsvd;
      cmd_st_nxt.sense_key = prot_rsvd ? `SK_ILLEGAL : 4'h0;
      cmd_st_nxt.asc = prot_rsvd ? `ASC_BAD_CDB : 8'h00;
    end
  end

  always_comb begin
    spin_nxt = '0;
    spin_nxt.pad_byte = `PAD_VALUE; // [RQ15]
    if (is_spin && !prot_rsvd) begin
      spin_nxt.valid = 1'b1;
      spin_nxt.xfer_len = xfer_len;
      spin_nxt.info = prot_info; // [RQ14]
      spin_nxt.has_data = res_read;
      spin_nxt.empty = !prot_info && !res_hit; // [RQ17]
      if (res_read && inc512 && (xfer_len > {9'h000, res_len_r})) begin
        spin_nxt.pad_len = xfer_len - {9'h000, res_len_r}; // [RQ15]
      end
    end
  end

  // Completion is reported only when the initiator is waiting for it
  always_comb begin
    done_st_nxt = '0;
    done_st_nxt.ascq = `ASCQ_NONE;
    if (!immed_r) begin
      if (hdr_done && parm_bad) begin
        done_st_nxt.valid = 1'b1; // [RQ11]
        done_st_nxt.check = 1'b1;
        done_st_nxt.sense_key = `SK_ILLEGAL;
        done_st_nxt.asc = `ASC_BAD_PARM;
      end else if (run_fail) begin
        done_st_nxt.valid = 1'b1;
        done_st_nxt.check = 1'b1;
        done_st_nxt.sense_key = `SK_MEDIUM;
        done_st_nxt.asc = `ASC_SAN_FAIL;
      end else if (state_r == ST_DONE) begin
        done_st_nxt.valid = 1'b1; // [RQ1]
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      o_busy <= 1'b0;
      o_parm_ready <= 1'b0;
      o_key_change <= 1'b0;
      o_cmd_status <= '0;
      o_done_status <= '0;
      o_spin <= '0;
    end else begin
      state_r <= state_nxt;
      o_busy <= state_nxt != ST_IDLE; // [RQ2]
      o_parm_ready <= state_nxt == ST_PARM;
      o_key_change <= san_start && sa_cry; // [RQ7]
      o_cmd_status <= cmd_st_nxt;
      o_done_status <= done_st_nxt;
      o_spin <= spin_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      immed_r <= 1'b0;
      uxf_r <= 1'b0;
      failed_r <= 1'b0;
      failed_uxf_r <= 1'b0;
    end else begin
      if (san_start) begin
        immed_r <= c_immed;
        uxf_r <= c_uxf;
      end
      if (run_fail) begin
        failed_r <= 1'b1;
        failed_uxf_r <= uxf_r; // [RQ3]
      end else if (is_san && sa_exit && !plen_bad && exit_ok) begin
        failed_r <= 1'b0; // [RQ8]
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      parm_idx_r <= 11'h000;
      inv_r <= 1'b0;
      ovw_cnt_r <= 5'h00;
      len_hi_r <= 8'h00;
      pat_len_r <= 10'h000;
    end else begin
      if (san_start) begin
        parm_idx_r <= 11'h000;
      end else if (parm_take) begin
        parm_idx_r <= parm_idx_r + 11'h001;
      end
      if (parm_take && (parm_idx_r == 11'h000)) begin
        inv_r <= i_parm_byte[`PINV_BIT];
        ovw_cnt_r <= i_parm_byte[`OVW_CNT_MSB:0]; // [RQ10]
      end
      if (parm_take && (parm_idx_r == `PARM_LEN_HI)) begin
        len_hi_r <= i_parm_byte;
      end
      if (hdr_done) begin
        pat_len_r <= pat_len_in[9:0];
      end
    end
  end

  // Output byte register doubles as the one-deep stall point
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wr_valid <= 1'b0;
      o_wr_byte <= 8'h00;
      pass_r <= 5'h00;
      blk_r <= 32'h00000000;
      all_done_r <= 1'b0;
    end else begin
      if (fill_take) begin
        o_wr_valid <= 1'b1;
        o_wr_byte <= gen_byte; // [RQ12] [RQ13]
      end else if (i_wr_ready || run_fail) begin
        o_wr_valid <= 1'b0;
      end
      if (hdr_done) begin
        pass_r <= 5'h00;
        blk_r <= 32'h00000000;
        all_done_r <= i_num_blocks == 32'h00000000;
      end else if (fill_take && gen_last) begin
        blk_r <= last_blk ? 32'h00000000 : blk_r + 32'h00000001;
        if (last_blk && last_pass) begin
          all_done_r <= 1'b1; // [RQ10]
        end else if (last_blk) begin
          pass_r <= pass_r + 5'h01; // [RQ9]
        end
      end
    end
  end

  // A new result wins over a read or loss in the same cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      res_valid_r <= 1'b0; // [RQ18]
      res_it_r <= 6'h00;
      res_lun_r <= 2'h0;
      res_len_r <= 32'h00000000;
    end else if (i_res_store) begin
      res_valid_r <= 1'b1;
      res_it_r <= i_res_it;
      res_lun_r <= i_res_lun;
      res_len_r <= i_res_len;
    end else if (res_read || res_lost) begin
      res_valid_r <= 1'b0; // [RQ18]
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_failed <= 1'b0;
    end else begin
      o_failed <= failed_r;
    end
  end

endmodule

// ---- tb/media_model.sv ----
// Medium-side model: stalling write sink and key change responder
`timescale 1ns/1ps

module media_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic i_key_en,
  input wire logic i_key_change,
  output logic o_wr_ready,
  output logic o_key_done
);
  logic [1:0] ph_r;
  logic [1:0] kc_r;

  // ****************************************************************
  // Back-pressure and key change
  // ****************************************************************
  // Ready drops one cycle in four, so the write stream must hold
  assign o_wr_ready = !(i_stall && ph_r == 2'h3);
  // Key never completes when disabled, so a failure can be injected
  assign o_key_done = kc_r[1] && i_key_en;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ph_r <= 2'h0;
      kc_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
      kc_r <= {kc_r[0], i_key_change};
    end
  end
endmodule

// ---- tb/sanitize_sec_in_assertions.sv ----
// Checker for command answers of the sanitize and security-in block
`timescale 1ns/1ps
`include "sanitize_consts.svh"

module sanitize_sec_in_chk
  import sanitize_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input sanitize_pkg::cdb_s i_cmd,
  input sanitize_pkg::status_s o_cmd_status,
  input sanitize_pkg::spin_s o_spin,
  input wire logic o_busy,
  input wire logic o_failed
);
  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire logic [7:0] op = i_cmd.bytes[95:88];
  wire logic san = i_cmd_valid && op == `OPC_SANITIZE;
  wire logic sec = i_cmd_valid && op == `OPC_SEC_IN;
  wire logic [4:0] sa = i_cmd.bytes[84:80];
  wire logic [7:0] prot = i_cmd.bytes[87:80];
  wire logic [31:0] alloc = i_cmd.bytes[47:16];
  wire logic pl0 = i_cmd.bytes[39:24] == 16'h0000;
  wire logic run = sa == `SA_OVERWRITE || sa == `SA_CRYPTO;
  wire logic rsvd = !run && sa != `SA_EXIT_FAIL;
  wire logic bad = o_cmd_status.valid && o_cmd_status.check &&
    o_cmd_status.sense_key == `SK_ILLEGAL && o_cmd_status.asc == `ASC_BAD_CDB;
  // Back-to-back starts excluded: o_busy is already high in the cycle after the first one
  wire logic start = san && pl0 && run && !o_busy;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // ****************************************************************
  // Properties
  // ****************************************************************
  plen_refuse_a: assert property (san && !pl0 |=> bad)
    else $error("nonzero parameter length not refused");
  rsvd_action_a: assert property (san && pl0 && rsvd |=> bad)
    else $error("reserved service action not refused");
  exit_refuse_a: assert property ((san && pl0 && sa == `SA_EXIT_FAIL &&
    !o_failed) ##1 !o_failed |-> bad)
    else $error("exit request without failure accepted");
  immed_good_a: assert property (start && i_cmd.bytes[87] &&
    !$past(i_cmd_valid) |=> o_cmd_status.valid && !o_cmd_status.check)
    else $error("immediate sanitize not answered good");
  defer_status_a: assert property (start && !i_cmd.bytes[87] &&
    !$past(i_cmd_valid) |=> !o_cmd_status.valid)
    else $error("deferred sanitize answered early");
  sec_rsvd_a: assert property (sec && prot > `PROT_EXT_LAST |=>
    bad && !o_spin.valid)
    else $error("reserved protocol not refused");
  sec_info_a: assert property (sec && prot == `PROT_INFO |=>
    o_spin.valid && o_spin.info)
    else $error("protocol information not flagged");
  unit_len_a: assert property (sec && prot <= `PROT_EXT_LAST &&
    i_cmd.bytes[63] |=> o_spin.xfer_len == {$past(alloc), 9'h000})
    else $error("512-byte unit length wrong");
  byte_len_a: assert property (sec && prot <= `PROT_EXT_LAST &&
    !i_cmd.bytes[63] |=> o_spin.xfer_len == {9'h000, $past(alloc)})
    else $error("byte unit length wrong");
  pad_zero_a: assert property (o_spin.valid |->
    o_spin.pad_byte == `PAD_VALUE)
    else $error("pad byte not zero");
endmodule

bind sanitize_sec_in sanitize_sec_in_chk i_chk (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd),
  .o_cmd_status(o_cmd_status),
  .o_spin(o_spin),
  .o_busy(o_busy),
  .o_failed(o_failed)
);

// ---- tb/sanitize_sec_in_tb.sv ----
// Self-checking bench for the sanitize and security-in block
`timescale 1ns/1ps
`include "sanitize_consts.svh"

module sanitize_sec_in_tb;
  import sanitize_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_cmd_valid = 1'b0;
  cdb_s i_cmd = '0;
  logic i_parm_valid = 1'b0;
  logic [7:0] i_parm_byte = 8'h00;
  logic i_media_fail = 1'b0;
  logic i_res_store = 1'b0;
  logic [5:0] i_res_it = 6'h00;
  logic i_it_loss = 1'b0;
  logic [5:0] i_loss_it = 6'h00;
  logic stall = 1'b0;
  logic key_en = 1'b0;
  logic o_parm_ready, o_wr_valid, i_wr_ready, o_key_change, i_key_done;
  logic o_busy, o_failed, kc_seen;
  logic [7:0] o_wr_byte;
  status_s o_cmd_status, o_done_status, cs_r, ds_r;
  spin_s o_spin, sp_r;
  logic [7:0] q[$];
  int miscompares = 0, cmp_count = 0, cyc = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  sanitize_sec_in i_sanitize_sec_in (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_parm_valid(i_parm_valid),
    .i_parm_byte(i_parm_byte), .o_parm_ready(o_parm_ready),
    .i_blk_len(16'h0004), .i_pi_len(4'h1), .i_num_blocks(32'h2),
    .o_wr_valid(o_wr_valid), .o_wr_byte(o_wr_byte), .i_wr_ready(i_wr_ready),
    .o_key_change(o_key_change), .i_key_done(i_key_done),
    .i_media_fail(i_media_fail), .o_cmd_status(o_cmd_status),
    .o_done_status(o_done_status), .o_spin(o_spin), .o_busy(o_busy),
    .o_failed(o_failed), .i_res_store(i_res_store), .i_res_it(i_res_it),
    .i_res_lun(2'h0), .i_res_len(32'd100), .i_it_loss(i_it_loss),
    .i_loss_it(i_loss_it));

  media_model i_media_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_stall(stall), .i_key_en(key_en), .i_key_change(o_key_change),
    .o_wr_ready(i_wr_ready), .o_key_done(i_key_done));

  // ****************************************************************
  // Monitors and helpers
  // ****************************************************************
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_cmd_status.valid) cs_r = o_cmd_status;
    if (o_done_status.valid) ds_r = o_done_status;
    if (o_spin.valid) sp_r = o_spin;
    if (o_key_change) kc_seen = 1'b1;
    if (o_wr_valid && i_wr_ready) q.push_back(o_wr_byte);
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task st(input status_s s, input logic [3:0] k, input logic [7:0] a);
    chk(64'({s.valid, s.check, s.sense_key, s.asc}), 64'({2'b11, k, a}));
  endtask

  function logic [95:0] san(input logic im, ux, input logic [4:0] a,
    input logic [15:0] pl);
    return {`OPC_SANITIZE, im, 1'b0, ux, a, 40'h0, pl, 24'h0};
  endfunction

  function logic [95:0] sec(input logic [7:0] p, input logic u,
    input logic [31:0] al);
    return {`OPC_SEC_IN, p, 16'h0, u, 15'h0, al, 16'h0};
  endfunction

  task cmd(input logic [95:0] b, input logic [5:0] it);
    cs_r = '0;
    ds_r = '0;
    sp_r = '0;
    kc_seen = 1'b0;
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b1;
    i_cmd = {b, it, 2'h0};
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b0;
    repeat (3) @(negedge i_clk_sys);
  endtask

  // Holds the byte until the edge that sees ready high
  task parm(input logic [7:0] b);
    i_parm_valid = 1'b1;
    i_parm_byte = b;
    @(posedge i_clk_sys);
    while (o_parm_ready !== 1'b1) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask

  task wait_ds;
    for (int i = 0; i < 400 && ds_r.valid !== 1'b1; i++) @(negedge i_clk_sys);
  endtask

  task keep(input logic [5:0] it, input logic [5:0] lost);
    @(negedge i_clk_sys);
    i_res_store = 1'b1;
    i_res_it = it;
    @(negedge i_clk_sys);
    i_res_store = 1'b0;
    i_it_loss = lost != 6'h00;
    i_loss_it = lost;
    @(negedge i_clk_sys);
    i_it_loss = 1'b0;
  endtask

  task wrap_up;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [7:0] pat [3] = '{8'ha1, 8'hb2, 8'hc3};
    logic [7:0] pb [7] = '{8'h82, 8'h00, 8'h00, 8'h03, 8'ha1, 8'hb2, 8'hc3};
    logic [4:0] rs [6] = '{5'h00, 5'h02, 5'h04, 5'h1e, 5'h1f, 5'h01};
    logic [7:0] eb [3] = '{8'h81, 8'h80, 8'h81};
    logic [7:0] el [3] = '{8'h05, 8'h01, 8'h00};
    logic [5:0] lt [2] = '{6'h03, 6'h02};
    logic [7:0] e;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk({o_busy, o_failed}, 2'b00);
    foreach (rs[i]) begin
      cmd(san(1'b1, 1'b1, rs[i], {15'h0, i == 5}), 6'h01);
      st(cs_r, `SK_ILLEGAL, `ASC_BAD_CDB);
    end
    $display("test refusals done");
    stall = 1'b1;
    cmd(san(1'b0, 1'b0, `SA_OVERWRITE, 16'h0), 6'h01);
    chk(cs_r.valid, 1'b0);
    foreach (pb[i]) parm(pb[i]);
    i_parm_valid = 1'b0;
    chk(o_busy, 1'b1);
    wait_ds();
    chk({ds_r.valid, ds_r.check, o_busy}, 3'b100);
    chk(q.size(), 20);
    foreach (q[n]) begin
      e = (n % 5 == 4) ? `PI_FILL : pat[(n % 5) % 3];
      chk(q[n] ^ ((n / 10 == 1) ? 8'hff : 8'h00), e);
    end
    foreach (eb[i]) begin
      cmd(san(1'b0, 1'b0, `SA_OVERWRITE, 16'h0), 6'h01);
      parm(eb[i]);
      parm(8'h00);
      parm(8'h00);
      parm(el[i]);
      i_parm_valid = 1'b0;
      wait_ds();
      st(ds_r, `SK_ILLEGAL, `ASC_BAD_PARM);
    end
    $display("test overwrite done");
    key_en = 1'b1;
    cmd(san(1'b0, 1'b0, `SA_CRYPTO, 16'h0), 6'h01);
    wait_ds();
    chk({ds_r.valid, ds_r.check, kc_seen}, 3'b101);
    key_en = 1'b0;
    for (int u = 1; u >= 0; u--) begin
      cmd(san(u[0], u[0], `SA_CRYPTO, 16'h0), 6'h01);
      chk({cs_r.valid, cs_r.check, kc_seen}, {u[0], 2'b01});
      cmd(san(1'b1, 1'b0, `SA_CRYPTO, 16'h0), 6'h01);
      st(cs_r, `SK_NOT_READY, `ASC_NOT_READY);
      i_media_fail = 1'b1;
      @(negedge i_clk_sys);
      i_media_fail = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      chk(o_failed, 1'b1);
      chk({ds_r.valid, ds_r.sense_key, ds_r.asc},
        u[0] ? 13'h0 : {1'b1, `SK_MEDIUM, `ASC_SAN_FAIL});
      cmd(san(1'b1, 1'b0, `SA_EXIT_FAIL, 16'h0), 6'h01);
      chk({cs_r.valid, cs_r.check, o_failed}, {1'b1, !u[0], !u[0]});
    end
    $display("test crypto done");
    cmd(sec(`PROT_INFO, 1'b0, 32'h10), 6'h01);
    chk({sp_r.valid, sp_r.info}, 2'b11);
    cmd(sec(8'hff, 1'b0, 32'h10), 6'h01);
    st(cs_r, `SK_ILLEGAL, `ASC_BAD_CDB);
    keep(6'h01, 6'h00);
    cmd(sec(8'h01, 1'b1, 32'h1), 6'h01);
    chk({sp_r.has_data, sp_r.xfer_len}, {1'b1, 41'd512});
    chk(sp_r.pad_len, 41'd412);
    cmd(sec(8'h06, 1'b0, 32'd300), 6'h01);
    chk({sp_r.empty, sp_r.xfer_len}, {1'b1, 41'd300});
    foreach (lt[i]) begin
      keep(6'h02, lt[i]);
      cmd(sec(8'h01, 1'b0, 32'd9), 6'h02);
      chk({sp_r.has_data, sp_r.empty}, {i == 0, i == 1});
    end
    keep(6'h01, 6'h00);
    i_rst = 1'b1;
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    cmd(sec(8'h01, 1'b0, 32'd9), 6'h01);
    chk(sp_r.empty, 1'b1);
    $display("test security done");
    wrap_up();
  end
endmodule
